// ===== common/tpc_pkg.sv
package tpc_pkg;
  // Timing base
  localparam int CLK_HZ    = 20_000_000;
  localparam int CLK_NS    = 50;
  localparam int LATCH_NS  = 2000;
  localparam int CLEAR_NS  = 2000;
  localparam int LATCH_CYC = (LATCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLEAR_CYC = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEB_US    = 5000;
  localparam int DEB_CYC   = DEB_US * (CLK_HZ / 1_000_000);

  // Serial clock chain
  localparam int PRE_DIV   = 9;
  localparam int BAUD_DIV  = 13;
  localparam int HALVINGS  = 4;
  localparam int RATES     = 5;
  localparam int RATE_W    = 3;
  localparam int OVERS     = 16;
  localparam int BYTE_W    = 8;
  localparam int STOP_IDX  = BYTE_W + 1;

  // Channels and counters
  localparam int N_CH      = 4;
  localparam int N_DATA    = 3;
  localparam int CH_TIME   = 3;
  localparam int DIGITS    = 3;
  localparam int DIG_W     = 4;
  localparam logic [3:0] DIG_MAX = 4'h9;

  // Ports and command fields
  localparam int NUM_PORTS   = 10;
  localparam int PORT_W      = 4;
  localparam int PORT_STRIDE = 2;
  localparam int PORT_ADC    = 6;
  localparam int PORT_STAT   = 8;
  localparam int CMD_RUN_BIT = 7;
  localparam int HI_NEW_BIT  = 7;
  localparam int HI_OVF_BIT  = 4;

  // Reset values
  localparam logic [22:0] SYNC_RST = 23'h000100;
endpackage

// ===== rtl/tpc_buf2.sv
module tpc_buf2 #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic         ce_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   fill;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  wire logic push = in_valid_in && in_ready_out;
  wire logic pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = fill != (AW + 1)'(DEPTH);
  assign out_valid_out = fill != '0;
  assign out_data_out  = mem[rp];

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wp   <= '0;
      rp   <= '0;
      fill <= '0;
    end else if (ce_in) begin
      if (push) begin
        mem[wp] <= in_data_in;
        wp      <= bump(wp);
      end
      if (pop) begin
        rp <= bump(rp);
      end
      if (push && !pop) begin
        fill <= fill + 1'b1;
      end else if (pop && !push) begin
        fill <= fill - 1'b1;
      end
    end
  end
endmodule

// ===== rtl/tpc_uart.sv
module tpc_uart
  import tpc_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              ce_in,
  input  wire logic              tick16_in,
  input  wire logic              rxd_in,
  input  wire logic [BYTE_W-1:0] tx_data_in,
  input  wire logic              tx_valid_in,
  output logic                   tx_ready_out,
  output logic                   txd_out,
  output logic [BYTE_W-1:0]      rx_data_out,
  output logic                   rx_valid_out
);
  localparam logic [3:0] HALF_T = 4'(OVERS / 2 - 1);
  localparam logic [3:0] LAST_T = 4'(OVERS - 1);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} tpc_rx_type;
  typedef enum logic {TX_IDLE, TX_SEND} tpc_tx_type;

  tpc_rx_type      rx_st;
  tpc_tx_type      tx_st;
  logic [3:0]      rx_tick;
  logic [2:0]      rx_bits;
  logic [3:0]      tx_tick;
  logic [3:0]      tx_bits;
  logic [BYTE_W:0] tx_sh;

  assign tx_ready_out = tx_st == TX_IDLE;

  // Eight data bits, no parity, sampled mid-bit on the 16x tick
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rx_st        <= RX_IDLE;
      rx_tick      <= '0;
      rx_bits      <= '0;
      rx_data_out  <= '0;
      rx_valid_out <= 1'b0;
    end else if (ce_in) begin
      rx_valid_out <= 1'b0;
      if (tick16_in) begin
        rx_tick <= rx_tick + 4'h1;
        unique case (rx_st)
          RX_IDLE: begin
            rx_tick <= '0;
            if (!rxd_in) rx_st <= RX_START;
          end
          RX_START: if (rx_tick == HALF_T) begin
            // A glitch shorter than half a bit is not a start
            rx_tick <= '0;
            rx_bits <= '0;
            rx_st   <= rxd_in ? RX_IDLE : RX_DATA;
          end
          RX_DATA: if (rx_tick == LAST_T) begin
            rx_data_out <= {rxd_in, rx_data_out[BYTE_W-1:1]};
            rx_bits     <= rx_bits + 3'h1;
            if (rx_bits == 3'h7) rx_st <= RX_STOP;
          end
          RX_STOP: if (rx_tick == LAST_T) begin
            rx_valid_out <= rxd_in;
            rx_st        <= RX_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      tx_st   <= TX_IDLE;
      tx_sh   <= '1;
      tx_tick <= '0;
      tx_bits <= '0;
      txd_out <= 1'b1;
    end else if (ce_in) begin
      unique case (tx_st)
        TX_IDLE: if (tx_valid_in) begin
          tx_sh   <= {1'b1, tx_data_in};
          txd_out <= 1'b0;
          tx_tick <= '0;
          tx_bits <= '0;
          tx_st   <= TX_SEND;
        end
        TX_SEND: if (tick16_in) begin
          tx_tick <= tx_tick + 4'h1;
          if (tx_tick == LAST_T) begin
            tx_bits <= tx_bits + 4'h1;
            txd_out <= tx_sh[0];
            tx_sh   <= {1'b1, tx_sh[BYTE_W:1]};
            if (tx_bits == 4'(STOP_IDX)) begin
              txd_out <= 1'b1;
              tx_st   <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule

// ===== rtl/tpc_top.sv
// How it works
// - Positive pulse sets, negative clears track flop
// - Repeated same-polarity pulses leave level unchanged
// - Master reset clears every track flop
// - Time track rise fires fixed-width latch strobe
// - Clear pulse starts when latch strobe ends
// - Three decimal digits per data channel
// - Overflow sets past 999, stays beyond 1999
// - Strobe captures count and overflow into holders
// - Clear pulse zeroes digits and overflow
// - Time track rise sets new-data flags
// - Only low-word select clears new-data flag
// - Low holder reaches bus only when selected
// - High select puts holder and flag on bus
// - Converter byte on bus only when selected
// - Debounced button, valid, busy read at port 8
// - Command top bit drives tape relay
// - Low nibble 0-9 decodes to one active select, 10-15 to none
// - Received byte answers with selected port byte
// - Eight data bits, no parity
// - Serial logic ticks at sixteen times rate
// - Divide by 9, 13, then four halvings
// - Switch picks about 10684 down to 668 baud
module tpc_top
  import tpc_pkg::*;
#(
  parameter int DEB_LEN = DEB_CYC
) (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              ce_in,
  input  wire logic [N_CH-1:0]   pos_pulse_in,
  input  wire logic [N_CH-1:0]   neg_pulse_in,
  input  wire logic              rxd_in,
  input  wire logic              button_in,
  input  wire logic [BYTE_W-1:0] adc_data_in,
  input  wire logic              adc_valid_in,
  input  wire logic              adc_busy_in,
  input  wire logic [RATE_W-1:0] rate_sel_in,
  output logic                   txd_out,
  output logic                   relay_out,
  output logic [NUM_PORTS-1:0]   port_sel_n_out,
  output logic [N_CH-1:0]        track_out
);
  localparam int SYNC_W = 23;
  localparam int TW     = $clog2((LATCH_CYC > CLEAR_CYC ? LATCH_CYC : CLEAR_CYC) + 1);
  localparam int DEB_W  = $clog2(DEB_LEN + 1);
  localparam int CW     = DIGITS * DIG_W;
  localparam logic [HALVINGS:0] ONE_H = (HALVINGS + 1)'(1);

  function automatic logic [CW:0] bcd_inc(input logic [CW-1:0] v);
    logic             c;
    logic [DIG_W-1:0] d;
    logic [CW-1:0]    r;
    c = 1'b1;
    r = v;
    for (int i = 0; i < DIGITS; i++) begin
      d = v[i*DIG_W +: DIG_W];
      if (c) begin
        if (d == DIG_MAX) begin
          d = '0;
        end else begin
          d = d + 4'h1;
          c = 1'b0;
        end
      end
      r[i*DIG_W +: DIG_W] = d;
    end
    return {c, r};
  endfunction

  function automatic logic [NUM_PORTS-1:0] port_dec(input logic [PORT_W-1:0] n);
    logic [NUM_PORTS-1:0] r;
    r = '1;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (n == PORT_W'(i)) r[i] = 1'b0;
    end
    return r;
  endfunction

  // Input synchronisers
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [N_CH-1:0]   pos_s;
  logic [N_CH-1:0]   neg_s;
  logic              rxd_s;
  logic              btn_s;
  logic [BYTE_W-1:0] adc_s;
  logic              valid_s;
  logic              busy_s;
  logic [RATE_W-1:0] rate_s;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
    end else if (ce_in) begin
      sync1 <= {rate_sel_in, adc_busy_in, adc_valid_in, adc_data_in,
                button_in, rxd_in, neg_pulse_in, pos_pulse_in};
      sync2 <= sync1;
    end
  end

  assign {rate_s, busy_s, valid_s, adc_s, btn_s, rxd_s, neg_s, pos_s} = sync2;

  // Track restoration
  logic [N_CH-1:0] track;
  logic [N_CH-1:0] track_d;
  wire logic [N_CH-1:0] set_pulse  = pos_s & ~neg_s;
  wire logic [N_CH-1:0] clr_pulse  = neg_s & ~pos_s;
  // Both comparators at once is noise: the level holds
  wire logic [N_CH-1:0] next_track = (track | set_pulse) & ~clr_pulse;
  wire logic [N_CH-1:0] rise       = track & ~track_d;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      track   <= '0;
      track_d <= '0;
    end else if (ce_in) begin
      track   <= next_track;
      track_d <= track;
    end
  end

  assign track_out = track;

  // Latch strobe, then clear pulse
  logic [TW-1:0] latch_cnt;
  logic [TW-1:0] clear_cnt;
  wire logic latch_act   = latch_cnt != '0;
  wire logic clear_act   = clear_cnt != '0;
  wire logic latch_last  = latch_cnt == TW'(1);
  // A time edge inside the strobe or the clear is dropped, not queued
  wire logic start_latch = rise[CH_TIME] && !latch_act && !clear_act;
  wire logic [TW-1:0] next_latch = start_latch ? TW'(LATCH_CYC) : (latch_act ? latch_cnt - 1'b1 : '0);
  wire logic [TW-1:0] next_clear = latch_last ? TW'(CLEAR_CYC) : (clear_act ? clear_cnt - 1'b1 : '0);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      latch_cnt <= '0;
      clear_cnt <= '0;
    end else if (ce_in) begin
      latch_cnt <= next_latch;
      clear_cnt <= next_clear;
    end
  end

  // Counters, holders, flags
  logic [CW-1:0]       cnt      [N_DATA];
  logic [CW-1:0]       next_cnt [N_DATA];
  logic [BYTE_W-1:0]   lo_hold  [N_DATA];
  logic [DIG_W:0]      hi_hold  [N_DATA];
  logic [BYTE_W-1:0]   ch_byte  [N_DATA];
  logic [N_DATA-1:0]   ovf;
  logic [N_DATA-1:0]   next_ovf;
  logic [N_DATA-1:0]   new_data;
  logic [N_DATA-1:0]   next_new;
  logic [N_DATA-1:0]   low_word_select_n;
  logic [N_DATA-1:0]   high_word_select_n;

  for (genvar c = 0; c < N_DATA; c++) begin : g_ch
    wire logic [CW:0] inc = bcd_inc(cnt[c]);
    assign low_word_select_n[c]  = port_sel_n_out[PORT_STRIDE*c];
    assign high_word_select_n[c] = port_sel_n_out[PORT_STRIDE*c+1];
    assign next_cnt[c] = clear_act ? '0 : (rise[c] ? inc[CW-1:0] : cnt[c]);
    assign next_ovf[c] = !clear_act && (ovf[c] || (rise[c] && inc[CW]));
    assign next_new[c] = rise[CH_TIME] || (new_data[c] && low_word_select_n[c]);
    assign ch_byte[c]  = (!low_word_select_n[c] ? lo_hold[c] : '0)
                       | (!high_word_select_n[c]
                          ? {new_data[c], 2'h0, hi_hold[c]} : '0);
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ovf      <= '0;
      new_data <= '0;
      for (int c = 0; c < N_DATA; c++) begin
        cnt[c]     <= '0;
        lo_hold[c] <= '0;
        hi_hold[c] <= '0;
      end
    end else if (ce_in) begin
      ovf      <= next_ovf;
      new_data <= next_new;
      for (int c = 0; c < N_DATA; c++) begin
        cnt[c] <= next_cnt[c];
        // Taken on the strobe's last cycle so no edge before it is lost
        if (latch_last) begin
          lo_hold[c] <= cnt[c][BYTE_W-1:0];
          hi_hold[c] <= {ovf[c], cnt[c][CW-1 -: DIG_W]};
        end
      end
    end
  end

  // Push button debounce
  logic             btn_db;
  logic [DEB_W-1:0] deb_cnt;
  wire logic             deb_done     = deb_cnt == DEB_W'(DEB_LEN - 1);
  wire logic [DEB_W-1:0] next_deb_cnt = (btn_s == btn_db || deb_done) ? '0 : deb_cnt + 1'b1;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      btn_db  <= 1'b0;
      deb_cnt <= '0;
    end else if (ce_in) begin
      deb_cnt <= next_deb_cnt;
      if (deb_done) btn_db <= btn_s;
    end
  end

  // Shared byte bus
  wire logic [BYTE_W-1:0] adc_term  = !port_sel_n_out[PORT_ADC] ? adc_s : '0;
  wire logic [BYTE_W-1:0] stat_term = !port_sel_n_out[PORT_STAT]
                                      ? {5'h00, busy_s, valid_s, btn_db} : '0;
  wire logic [BYTE_W-1:0] bus_byte  = ch_byte[0] | ch_byte[1] | ch_byte[2] | adc_term | stat_term;

  // Serial clock chain
  logic [3:0]          pre_cnt;
  logic [3:0]          baud_cnt;
  logic [HALVINGS-1:0] half_cnt;
  wire logic pre_tick  = pre_cnt == 4'(PRE_DIV - 1);
  wire logic baud_tick = pre_tick && baud_cnt == 4'(BAUD_DIV - 1);
  wire logic [HALVINGS:0]   rate_pow  = (ONE_H << rate_s) - ONE_H;
  // Codes above the slowest rate fall back to the slowest
  wire logic [HALVINGS-1:0] rate_mask = (rate_s >= RATE_W'(RATES)) ? '1 : rate_pow[HALVINGS-1:0];
  wire logic tick16 = baud_tick && ((half_cnt & rate_mask) == rate_mask);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pre_cnt  <= '0;
      baud_cnt <= '0;
      half_cnt <= '0;
    end else if (ce_in) begin
      pre_cnt <= pre_tick ? '0 : pre_cnt + 4'h1;
      if (pre_tick) baud_cnt <= baud_tick ? '0 : baud_cnt + 4'h1;
      if (baud_tick) half_cnt <= half_cnt + 1'b1;
    end
  end

  // Command handling and reply
  logic              rx_valid;
  logic [BYTE_W-1:0] rx_data;
  logic              pend;
  logic              buf_in_ready;
  logic              buf_out_valid;
  logic              tx_ready;
  logic [BYTE_W-1:0] buf_out_data;
  // A fresh command beats the push that retires the old one
  wire logic next_pend = rx_valid || (pend && !buf_in_ready);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pend           <= 1'b0;
      relay_out      <= 1'b0;
      port_sel_n_out <= '1;
    end else if (ce_in) begin
      pend <= next_pend;
      if (rx_valid) begin
        relay_out      <= rx_data[CMD_RUN_BIT];
        port_sel_n_out <= port_dec(rx_data[PORT_W-1:0]);
      end
    end
  end

  tpc_buf2 #(
    .W     (BYTE_W),
    .DEPTH (2)
  ) u_buf (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .ce_in         (ce_in),
    .in_valid_in   (pend),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (bus_byte),
    .out_valid_out (buf_out_valid),
    .out_ready_in  (tx_ready),
    .out_data_out  (buf_out_data)
  );

  tpc_uart u_uart (
    .clk_in       (clk_in),
    .resetn_in    (resetn_in),
    .ce_in        (ce_in),
    .tick16_in    (tick16),
    .rxd_in       (rxd_s),
    .tx_data_in   (buf_out_data),
    .tx_valid_in  (buf_out_valid),
    .tx_ready_out (tx_ready),
    .txd_out      (txd_out),
    .rx_data_out  (rx_data),
    .rx_valid_out (rx_valid)
  );

  // Checks
  AST_TRACK_SET: assert property (@(posedge clk_in) disable iff (!resetn_in || !ce_in)
    set_pulse[0] |=> track[0]) else $error("track not set by positive pulse");
  AST_TRACK_HOLD: assert property (@(posedge clk_in) disable iff (!resetn_in || !ce_in)
    (pos_s[0] == neg_s[0]) |=> $stable(track[0])) else $error("track moved without a lone pulse");
  AST_RESET_CLEAR: assert property (@(posedge clk_in)
    !resetn_in |=> track == '0) else $error("reset left a track set");
  AST_LATCH_START: assert property (@(posedge clk_in) disable iff (!resetn_in || !ce_in)
    start_latch |=> latch_cnt == TW'(LATCH_CYC)) else $error("latch strobe not started");
  AST_CLEAR_AFTER: assert property (@(posedge clk_in) disable iff (!resetn_in || !ce_in)
    $fell(latch_act) |-> clear_cnt == TW'(CLEAR_CYC)) else $error("clear did not follow strobe");
  AST_OVF_KEEP: assert property (@(posedge clk_in) disable iff (!resetn_in || !ce_in)
    ovf[0] && !clear_act |=> ovf[0]) else $error("overflow dropped without clear");
  AST_CAPTURE: assert property (@(posedge clk_in) disable iff (!resetn_in || !ce_in)
    latch_last |=> lo_hold[0] == $past(cnt[0][BYTE_W-1:0])) else $error("count not captured");
  AST_CLEAR_ZERO: assert property (@(posedge clk_in) disable iff (!resetn_in || !ce_in)
    clear_act |=> cnt[0] == '0 && !ovf[0]) else $error("clear did not zero counter");
  AST_NEW_HOLD: assert property (@(posedge clk_in) disable iff (!resetn_in || !ce_in)
    new_data[0] && low_word_select_n[0] |=> new_data[0]) else $error("new-data lost unselected");
  AST_ONE_SEL: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $onehot0(~port_sel_n_out)) else $error("more than one port selected");
  AST_RELAY: assert property (@(posedge clk_in) disable iff (!resetn_in || !ce_in)
    rx_valid |=> relay_out == $past(rx_data[CMD_RUN_BIT])) else $error("relay not from command");
  AST_REPLY: assert property (@(posedge clk_in) disable iff (!resetn_in || !ce_in)
    rx_valid |=> pend) else $error("command did not queue a reply");
  AST_COUNT: assert property (@(posedge clk_in) disable iff (!resetn_in || !ce_in)
    rise[0] && !clear_act && cnt[0] == 12'h009 |=> cnt[0] == 12'h010) else $error("decimal carry wrong");
endmodule

// ===== bench/tpc_host.sv
module tpc_host
  import tpc_pkg::*;
#(
  parameter int BIT_CYC = PRE_DIV * BAUD_DIV * OVERS
) (
  input  wire logic clk_in,
  input  wire logic txd_in,
  output logic      rxd_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [BYTE_W-1:0] rx_q[$];
  logic [BYTE_W-1:0] shift;
  int                frame_err = 0;

  // Line rests at mark between frames
  initial rxd_out = 1'b1;

  task automatic send_byte(input logic [BYTE_W-1:0] b);
    @(negedge clk_in);
    rxd_out = 1'b0;
    repeat (BIT_CYC) @(negedge clk_in);
    for (int i = 0; i < BYTE_W; i++) begin
      rxd_out = b[i];
      repeat (BIT_CYC) @(negedge clk_in);
    end
    rxd_out = 1'b1;
    repeat (BIT_CYC) @(negedge clk_in);
  endtask

  // Mid-bit sampling tolerates the tick phase offset
  always begin
    @(negedge txd_in);
    repeat (BIT_CYC / 2) @(posedge clk_in);
    if (txd_in !== 1'b0) frame_err++;
    for (int i = 0; i < BYTE_W; i++) begin
      repeat (BIT_CYC) @(posedge clk_in);
      shift[i] = txd_in;
    end
    repeat (BIT_CYC) @(posedge clk_in);
    if (txd_in !== 1'b1) frame_err++;
    rx_q.push_back(shift);
  end
endmodule

// ===== bench/tpc_top_tb.sv
module tpc_top_tb
  import tpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int BIT_CYC = PRE_DIV * BAUD_DIV * OVERS;

  logic                 clk_in    = 1'b0;
  logic                 resetn_in = 1'b0;
  logic                 ce        = 1'b1;
  logic [N_CH-1:0]      pos       = 4'h0;
  logic [N_CH-1:0]      neg       = 4'h0;
  logic                 button    = 1'b1;
  logic [BYTE_W-1:0]    adc_data  = 8'ha5;
  logic                 adc_valid = 1'b0;
  logic                 adc_busy  = 1'b1;
  wire logic            rxd;
  wire logic            txd;
  wire logic            relay;
  wire logic [NUM_PORTS-1:0] sel;
  wire logic [N_CH-1:0] track;
  int                   err_total = 0;
  int                   cmp_count = 0;

  always #(CLK_NS / 2) clk_in = ~clk_in;

  tpc_top #(
    .DEB_LEN(4)
  ) DUT (
    .clk_in         (clk_in),
    .resetn_in      (resetn_in),
    .ce_in          (ce),
    .pos_pulse_in   (pos),
    .neg_pulse_in   (neg),
    .rxd_in         (rxd),
    .button_in      (button),
    .adc_data_in    (adc_data),
    .adc_valid_in   (adc_valid),
    .adc_busy_in    (adc_busy),
    .rate_sel_in    (3'h0),
    .txd_out        (txd),
    .relay_out      (relay),
    .port_sel_n_out (sel),
    .track_out      (track)
  );

  tpc_host host (
    .clk_in  (clk_in),
    .txd_in  (txd),
    .rxd_out (rxd)
  );

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One comparator hit of each polarity, long enough for the synchronisers
  task automatic pulse(input logic [N_CH-1:0] m);
    @(negedge clk_in);
    pos = m;
    repeat (3) @(negedge clk_in);
    pos = 4'h0;
    neg = m;
    repeat (3) @(negedge clk_in);
    neg = 4'h0;
  endtask

  task automatic time_mark;
    pulse(4'h8);
    repeat (100) @(negedge clk_in);
  endtask

  task automatic t_reset_vals;
    check("track_rst", 16'h0, {12'h0, track});
    check("sel_rst", 16'h03ff, {6'h0, sel});
    check("relay_rst", 16'h0, {15'h0, relay});
    check("txd_idle", 16'h1, {15'h0, txd});
  endtask

  // Count 1500 passes 999, so overflow shows beside hundreds digit 5
  task automatic t_first_reply;
    for (int i = 0; i < 1500; i++) pulse(4'h1);
    time_mark();
    host.send_byte(8'h81);
    for (int n = 0; n < 12 * BIT_CYC && host.rx_q.size() < 1; n++) @(negedge clk_in);
    check("first_reply", 16'h0095, {8'h0, host.rx_q[0]});
  endtask

  task automatic t_tracks;
    @(negedge clk_in);
    pos = 4'h1;
    repeat (4) @(negedge clk_in);
    pos = 4'h0;
    repeat (3) @(negedge clk_in);
    check("track_set", 16'h1, {12'h0, track});
    pos = 4'h1;
    repeat (4) @(negedge clk_in);
    pos = 4'h0;
    repeat (3) @(negedge clk_in);
    check("track_hold", 16'h1, {12'h0, track});
    neg = 4'h1;
    repeat (4) @(negedge clk_in);
    neg = 4'h0;
    repeat (3) @(negedge clk_in);
    check("track_clr", 16'h0, {12'h0, track});
    // Enable low freezes the synchronisers, so this pulse is never seen
    ce = 1'b0;
    pos = 4'h1;
    repeat (4) @(negedge clk_in);
    pos = 4'h0;
    ce = 1'b1;
    repeat (3) @(negedge clk_in);
    check("track_frozen", 16'h0, {12'h0, track});
  endtask

  // Commands are a frame plus 200 cycles apart, so each reply is sent before the next command is taken
  task automatic t_reads;
    logic [7:0] cmd [6] = '{8'h00, 8'h01, 8'h83, 8'h05, 8'h88, 8'h06};
    logic [7:0] exp [6] = '{8'h56, 8'h00, 8'h90, 8'h89, 8'h05, 8'ha5};
    for (int i = 0; i < 2003; i++) pulse({1'b0, (i < 999), 1'b1, (i < 55)});
    time_mark();
    for (int k = 0; k < 6; k++) begin
      host.send_byte(cmd[k]);
      repeat (200) @(negedge clk_in);
      check("relay", {15'h0, cmd[k][7]}, {15'h0, relay});
      check("select", {6'h0, ~(10'h1 << cmd[k][3:0])}, {6'h0, sel});
    end
    for (int n = 0; n < 30 * BIT_CYC && host.rx_q.size() < 7; n++) @(negedge clk_in);
    for (int k = 0; k < 6; k++) begin
      check("reply", {8'h0, exp[k]}, {8'h0, host.rx_q[k + 1]});
    end
  endtask

  initial begin
    repeat (12) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_reset_vals();
    t_first_reply();
    t_tracks();
    t_reads();
    check("frame_err", 16'h0, host.frame_err[15:0]);
    end_of_test();
  end

  // Serial traffic dominates the run time
  initial begin
    repeat (300000) @(posedge clk_in);
    err_total++;
    $display("[FAIL] watchdog expected done seen timeout");
    end_of_test();
  end
endmodule
